// ===== src/tec_counter.sv
// 16-bit timer/event counter with prescaler, byte-pair access and Wishbone slave
//
// Operation
// - One 16-bit up-counter: interval timer, event counter or pulse width unit.
// - A 16-stage prescaler sits in the internal timer clock path.
// - Writing the byte pair loads preload; reading it returns the live counter.
// - Timer and pulse modes use system clock; event mode uses the input pin.
// - Each qualifying input edge in event mode adds exactly one, unless it meets a counter byte access.
// - Past FFFFH the counter reloads preload, raises the request, keeps counting.
// - Preload has no defined power-on value; software must write it first.
// - While stopped, a preload write is copied straight into the counter.
// - While running, a new preload reaches the counter only at next overflow.
// - Low byte writes land in a buffer, not in preload or counter.
// - High byte write stores high byte and moves buffered low byte together.
// - High byte read returns counter high and captures counter low in buffer.
// - Low byte read returns the captured byte, not the live low byte.
// - Control bit 4 is run: high counts, low stops.
// - Control bit 3 selects input edge polarity in event and pulse modes.
// - Mode bits high=1, low=0 select interval timer mode.
// - Interval mode adds one on each falling edge of the prescaled clock.
// - Overflow request is passed on only while the enable bit is set.
// - Overflow never wakes the device from halt.
// - Event mode counts rising edges with edge select low, falling when high.
// - Mode bits high=0, low=1 select event counting mode.
// - Both mode bits high: pulse mode counts prescaler ticks while input not idle.
// - Pulse end clears run itself; later edges ignored until run set again.
`timescale 1ns/1ps

module tec_counter
    import tec_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PSC_STAGES = TEC_PSC_DEFAULT
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [TEC_DATA_W-1:0] wb_dat_i,
    output logic [TEC_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_count_input_i,
    output logic timer_irq_o
);

    // Elaboration checks: the prescaler taps reach stage 15 and offsets need 8 bits
    if (PSC_STAGES < 16) begin : g_psc_chk
        $error("PSC_STAGES must be at least 16");
    end
    if (ADDR_W < 8) begin : g_adr_chk
        $error("ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic ack;
        logic [TEC_DATA_W-1:0] dat;
        logic irq;
        logic [TEC_CNT_W-1:0] cnt;
        logic [TEC_CNT_W-1:0] preload;
        logic [TEC_BYTE_W-1:0] wr_low;
        logic [TEC_BYTE_W-1:0] rd_low;
        logic [TEC_BYTE_W-1:0] ctrl;
        logic ien;
        logic iflag;
        logic [PSC_STAGES-1:0] psc;
        logic sync1;
        logic sync2;
        logic sync3;
        logic pw_active;
    } tec_state_t;

    tec_state_t r_reg;
    tec_state_t r_next;

    // Decoded helpers, also watched by the assertions
    logic [ADDR_W-1:0] adr_al;
    logic req;
    logic hit_low;
    logic hit_high;
    logic hit_ctrl;
    logic hit_interrupt_control_reg;
    logic wr_en;
    logic rd_en;
    logic cnt_access;
    logic tick;
    logic [3:0] tap;
    logic rise;
    logic fall;
    logic ev_edge;
    logic leave_idle;
    logic back_idle;
    logic run;
    logic inc;
    logic ovf;
    tec_mode_t mode;

    // Next-state logic for the whole block
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.dat = '0;

        // Wishbone decode; a request is taken once, ack follows one cycle later
        adr_al = {wb_adr_i[ADDR_W-1:2], 2'b00};
        req = wb_cyc_i & wb_stb_i & ~r_reg.ack;
        hit_low = (adr_al == ADDR_W'(TEC_OFF_LOW));
        hit_high = (adr_al == ADDR_W'(TEC_OFF_HIGH));
        hit_ctrl = (adr_al == ADDR_W'(TEC_OFF_CTRL));
        hit_interrupt_control_reg = (adr_al == ADDR_W'(TEC_OFF_INTERRUPT_CONTROL_REG));
        wr_en = req & wb_we_i & wb_sel_i[0];
        rd_en = req & ~wb_we_i;
        // Counting is inhibited for the cycle of a counter access, so the
        // byte transfer never races an increment; this may lose one count
        cnt_access = req & (hit_low | hit_high);
        r_next.ack = req;

        // Free-running prescaler; the tap doubles as rate select
        r_next.psc = r_reg.psc + 1'b1;
        tap = {r_reg.ctrl[TEC_PSC_MSB:TEC_PSC_LSB], 1'b1};
        tick = r_reg.psc[tap] & ~r_next.psc[tap];

        // Two-flop synchroniser plus one stage for edge detection
        r_next.sync1 = external_count_input_i;
        r_next.sync2 = r_reg.sync1;
        r_next.sync3 = r_reg.sync2;
        rise = r_reg.sync2 & ~r_reg.sync3;
        fall = ~r_reg.sync2 & r_reg.sync3;

        // Edge select picks polarity for both pin-driven modes
        ev_edge = r_reg.ctrl[TEC_EDGE_BIT] ? fall : rise;
        leave_idle = r_reg.ctrl[TEC_EDGE_BIT] ? rise : fall;
        back_idle = r_reg.ctrl[TEC_EDGE_BIT] ? fall : rise;

        run = r_reg.ctrl[TEC_RUN_BIT];
        mode = tec_mode_t'({r_reg.ctrl[TEC_MODE_HI_BIT], r_reg.ctrl[TEC_MODE_LO_BIT]});
        inc = 1'b0;

        // Clock source and gating per mode
        unique case (mode)
            TEC_MODE_STOP: begin
                inc = 1'b0;
            end
            TEC_MODE_TIMER: begin
                inc = run & tick;
            end
            TEC_MODE_EVENT: begin
                inc = run & ev_edge;
            end
            TEC_MODE_PULSE: begin
                // Count prescaler ticks only between leaving and regaining idle
                inc = run & r_reg.pw_active & tick;
                if (run && !r_reg.pw_active && leave_idle) begin
                    r_next.pw_active = 1'b1;
                end else if (run && r_reg.pw_active && back_idle) begin
                    r_next.pw_active = 1'b0;
                    r_next.ctrl[TEC_RUN_BIT] = 1'b0;
                end
            end
        endcase
        // Once stopped, pin edges are ignored until software restarts it
        if (!run) begin
            r_next.pw_active = 1'b0;
        end

        // Increment and overflow reload
        ovf = 1'b0;
        if (inc && !cnt_access) begin
            if (r_reg.cnt == TEC_COUNT_MAX) begin
                r_next.cnt = r_reg.preload;
                ovf = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt + TEC_COUNT_ONE;
            end
        end

        // Register writes
        if (wr_en) begin
            if (hit_low) begin
                r_next.wr_low = wb_dat_i[TEC_BYTE_W-1:0];
            end
            if (hit_high) begin
                // Buffered low byte joins the high byte in one update
                r_next.preload = {wb_dat_i[TEC_BYTE_W-1:0], r_reg.wr_low};
                if (!run) begin
                    r_next.cnt = {wb_dat_i[TEC_BYTE_W-1:0], r_reg.wr_low};
                end
            end
            if (hit_ctrl) begin
                // Software write wins over a same-cycle pulse-end clear
                r_next.ctrl = wb_dat_i[TEC_BYTE_W-1:0] & TEC_CTRL_MASK;
            end
            if (hit_interrupt_control_reg) begin
                r_next.ien = wb_dat_i[TEC_IEN_BIT];
                // Writing zero clears the flag; writing one leaves it
                if (!wb_dat_i[TEC_IFLAG_BIT]) begin
                    r_next.iflag = 1'b0;
                end
            end
        end

        // Overflow sets the flag after any clear, so a same-cycle event is kept
        if (ovf) begin
            r_next.iflag = 1'b1;
        end

        // Register reads; a high byte read also captures the low byte
        if (rd_en) begin
            if (hit_low) begin
                r_next.dat[TEC_BYTE_W-1:0] = r_reg.rd_low;
            end
            if (hit_high) begin
                r_next.dat[TEC_BYTE_W-1:0] = r_reg.cnt[TEC_CNT_W-1:TEC_BYTE_W];
                r_next.rd_low = r_reg.cnt[TEC_BYTE_W-1:0];
            end
            if (hit_ctrl) begin
                r_next.dat[TEC_BYTE_W-1:0] = r_reg.ctrl;
            end
            if (hit_interrupt_control_reg) begin
                r_next.dat[TEC_IEN_BIT] = r_reg.ien;
                r_next.dat[TEC_IFLAG_BIT] = r_reg.iflag;
            end
        end

        // Request line only; nothing here reaches a wake-up path
        r_next.irq = r_next.iflag & r_next.ien;
    end

    // State register; preload and buffers get a fixed value only so that
    // simulation stays clean, software must treat preload as unknown
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_reg <= '0;
            r_reg.ctrl <= TEC_CTRL_RST;
            r_reg.preload <= TEC_PRELOAD_POR;
            r_reg.cnt <= TEC_PRELOAD_POR;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state flops
    assign wb_ack_o = r_reg.ack;
    assign wb_dat_o = r_reg.dat;
    assign timer_irq_o = r_reg.irq;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Wishbone answers exactly one cycle after a taken request
    ack_latency_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");

    // Stopped counter with a high write takes the full new word
    stopped_load_a: assert property (
        wr_en && hit_high && !run |=>
        r_reg.cnt == {$past(wb_dat_i[7:0]), $past(r_reg.wr_low)})
        else $error("stopped counter did not take preload");

    // Running counter keeps its value while preload alone changes
    running_load_a: assert property (
        wr_en && hit_high && run |=>
        r_reg.cnt == $past(r_reg.cnt) &&
        r_reg.preload == {$past(wb_dat_i[7:0]), $past(r_reg.wr_low)})
        else $error("running preload write disturbed counter");

    // Low byte write touches neither preload nor counter
    low_buffer_a: assert property (
        wr_en && hit_low |=> $stable(r_reg.preload) && $stable(r_reg.cnt))
        else $error("low byte write leaked through");

    // High byte read returns counter high and latches counter low
    high_read_a: assert property (
        rd_en && hit_high |=> r_reg.rd_low == $past(r_reg.cnt[7:0]) &&
        wb_dat_o[7:0] == $past(r_reg.cnt[15:8]))
        else $error("high read capture wrong");

    // Low byte read returns the captured byte
    low_read_a: assert property (
        rd_en && hit_low |=> wb_dat_o[7:0] == $past(r_reg.rd_low))
        else $error("low read not from buffer");

    // Overflow reloads preload and raises the flag
    overflow_reload_a: assert property (
        inc && !cnt_access && r_reg.cnt == TEC_COUNT_MAX |=>
        r_reg.cnt == $past(r_reg.preload) && r_reg.iflag)
        else $error("overflow did not reload");

    // Each event edge adds exactly one
    event_step_a: assert property (
        mode == TEC_MODE_EVENT && run && ev_edge && !cnt_access &&
        r_reg.cnt != TEC_COUNT_MAX |=> r_reg.cnt == $past(r_reg.cnt) + TEC_COUNT_ONE)
        else $error("event edge miscounted");

    // Request only while the enable bit is set
    irq_gate_a: assert property (timer_irq_o |-> r_reg.ien && r_reg.iflag)
        else $error("request passed while disabled");

    // Pulse end clears run within one cycle
    pulse_stop_a: assert property (
        mode == TEC_MODE_PULSE && run && r_reg.pw_active && back_idle &&
        !(wr_en && hit_ctrl) |=> !r_reg.ctrl[TEC_RUN_BIT] ##1 !r_reg.pw_active)
        else $error("pulse end did not stop counter");

    // Stopped counter holds unless software loads it
    stopped_hold_a: assert property (
        !run && !(wr_en && hit_high) |=> $stable(r_reg.cnt))
        else $error("stopped counter moved");

    // Timer mode counts only on prescaler ticks
    timer_tick_a: assert property (
        mode == TEC_MODE_TIMER && run && !tick && !(wr_en && hit_high) |=>
        $stable(r_reg.cnt))
        else $error("timer counted without tick");

    // Timer mode adds exactly one on each prescaler tick
    timer_step_a: assert property (
        mode == TEC_MODE_TIMER && run && tick && !cnt_access &&
        r_reg.cnt != TEC_COUNT_MAX |=> r_reg.cnt == $past(r_reg.cnt) + TEC_COUNT_ONE)
        else $error("timer tick miscounted");

    // Stop mode never counts, whatever the run bit says
    mode_stop_a: assert property (
        mode == TEC_MODE_STOP && !(wr_en && hit_high) |=> $stable(r_reg.cnt))
        else $error("stop mode counted");

    // Event mode ignores edges of the other polarity
    event_hold_a: assert property (
        mode == TEC_MODE_EVENT && run && !ev_edge |=> $stable(r_reg.cnt))
        else $error("event counter moved without edge");

    // Pulse mode waits for the input to leave idle before counting
    pulse_idle_a: assert property (
        mode == TEC_MODE_PULSE && !r_reg.pw_active && !(wr_en && hit_high) |=>
        $stable(r_reg.cnt))
        else $error("pulse counter ran while idle");

    // Leaving idle with run set opens the measurement
    pulse_start_a: assert property (
        mode == TEC_MODE_PULSE && run && !r_reg.pw_active && leave_idle |=> r_reg.pw_active)
        else $error("pulse start missed");

    // Enabled overflow reaches the request output one cycle later
    irq_follow_a: assert property (
        ovf && r_reg.ien && !(wr_en && hit_interrupt_control_reg) |=> timer_irq_o)
        else $error("enabled overflow gave no request");

    // A clear enable keeps the request low
    irq_masked_a: assert property (
        !r_reg.ien && !(wr_en && hit_interrupt_control_reg) |=> !timer_irq_o)
        else $error("request raised with enable clear");

    // Writing zero to the flag clears it unless an overflow lands then
    flag_clear_a: assert property (
        wr_en && hit_interrupt_control_reg && !wb_dat_i[TEC_IFLAG_BIT] && !ovf |=> !r_reg.iflag)
        else $error("flag clear ignored");

    // Edges come from the synchronised pin, two clocks late
    sync_edge_a: assert property (
        rise |-> $past(external_count_input_i, 2))
        else $error("edge not from synchronised pin");

    cov_overflow_c: cover property (ovf);
    cov_pulse_end_c: cover property (mode == TEC_MODE_PULSE && run ##1 !run);
    cov_event_c: cover property (mode == TEC_MODE_EVENT && inc);
    cov_high_read_c: cover property (rd_en && hit_high ##[2:3] rd_en && hit_low);
    cov_timer_c: cover property (mode == TEC_MODE_TIMER && inc);

endmodule

// ===== src/tec_pkg.sv
// Constants and types shared by the 16-bit timer/event counter
package tec_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] TEC_OFF_LOW = 8'h00;
    localparam logic [7:0] TEC_OFF_HIGH = 8'h04;
    localparam logic [7:0] TEC_OFF_CTRL = 8'h08;
    localparam logic [7:0] TEC_OFF_INTERRUPT_CONTROL_REG = 8'h0C;

    // Field positions in counter_control
    localparam int TEC_MODE_HI_BIT = 7;
    localparam int TEC_MODE_LO_BIT = 6;
    localparam int TEC_RUN_BIT = 4;
    localparam int TEC_EDGE_BIT = 3;
    localparam int TEC_PSC_MSB = 2;
    localparam int TEC_PSC_LSB = 0;
    // Writable bits of counter_control; bit 5 is reserved and reads zero
    localparam logic [7:0] TEC_CTRL_MASK = 8'hDF;

    // Field positions in interrupt_control_reg
    localparam int TEC_IEN_BIT = 0;
    localparam int TEC_IFLAG_BIT = 1;

    // Reset values, count limit and increment
    localparam logic [7:0] TEC_CTRL_RST = 8'h00;
    localparam logic [15:0] TEC_PRELOAD_POR = 16'h0000;
    localparam logic [15:0] TEC_COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] TEC_COUNT_ONE = 16'h0001;

    // Counter and bus widths
    localparam int TEC_CNT_W = 16;
    localparam int TEC_BYTE_W = 8;
    localparam int TEC_DATA_W = 32;
    localparam int TEC_PSC_DEFAULT = 16;

    // Mode selected by mode_bit_high, mode_bit_low
    typedef enum logic [1:0] {
        TEC_MODE_STOP = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PULSE = 2'b11
    } tec_mode_t;

endpackage

// ===== tb/tec_pulse_src.sv
// Behavioural source for the external count pin of the timer/event counter
`timescale 1ns/1ps

module tec_pulse_src (
    input wire logic clk_i,
    output logic pin_o
);
    // Pin starts low; each level is held well over two clocks so the sync stages see it
    initial pin_o = 1'b0;

    // Move the pin to one level, then let the synchroniser settle
    task automatic set_level(input logic v);
        @(posedge clk_i);
        pin_o <= v;
        repeat (4) @(posedge clk_i);
    endtask

    // Excursions away from the present level and back, w clocks per level
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= ~pin_o;
            repeat (w) @(posedge clk_i);
            pin_o <= ~pin_o;
            repeat (w) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// ===== tb/timer_event_counter_16bit_tb.sv
// Self-checking bench for the 16-bit timer/event counter
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module timer_event_counter_16bit_tb;
    import tec_pkg::*;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h00000000;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic timer_irq;
    logic pin;
    int mismatches = 0;
    int comparisons = 0;
    logic [7:0] rd;
    logic [15:0] cnt, c2;

    // 125 MHz system clock
    always #4 sys_clk_i = ~sys_clk_i;

    tec_counter dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .external_count_input_i(pin), .timer_irq_o(timer_irq));
    tec_pulse_src src (.clk_i(sys_clk_i), .pin_o(pin));

    task wrap_up;
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One classic cycle; request held until ack is sampled, data taken at that edge
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge sys_clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 16);
        if (wb_ack !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED bus ack expected 1 seen timeout");
            wrap_up();
        end
        q = wb_dat_r[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task rd8(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask

    // Low byte first, so the high write commits both together
    task set_pre(input logic [15:0] v);
        wr(TEC_OFF_LOW, v[7:0]);
        wr(TEC_OFF_HIGH, v[15:8]);
    endtask

    // High read first latches the low byte for the following low read
    task get_cnt(output logic [15:0] v);
        logic [7:0] h, l;
        rd8(TEC_OFF_HIGH, h);
        rd8(TEC_OFF_LOW, l);
        v = {h, l};
    endtask

    task t_reset;
        rd8(TEC_OFF_CTRL, rd);
        `CHK("control reset", 8'h00, rd)
        rd8(TEC_OFF_INTERRUPT_CONTROL_REG, rd);
        `CHK("interrupt_control_reg reset", 8'h00, rd)
        rd8(8'h10, rd);
        `CHK("unmapped read", 8'h00, rd)
        `CHK("irq idle", 1'b0, timer_irq)
    endtask

    task t_bytes;
        wr(TEC_OFF_LOW, 8'h34);
        get_cnt(cnt);
        `CHK("low write buffered", 16'h0000, cnt)
        wr(TEC_OFF_HIGH, 8'h12);
        get_cnt(cnt);
        `CHK("pair load stopped", 16'h1234, cnt)
    endtask

    task t_event;
        wr(TEC_OFF_CTRL, 8'h40);
        wr(TEC_OFF_CTRL, 8'h50);
        src.pulses(5, 3);
        wr(TEC_OFF_CTRL, 8'h40);
        rd8(TEC_OFF_LOW, rd);
        `CHK("low read latched", 8'h34, rd)
        get_cnt(cnt);
        `CHK("rising edges", 16'h1239, cnt)
        // Reserved bit 5 is written high and must read back zero
        wr(TEC_OFF_CTRL, 8'h68);
        rd8(TEC_OFF_CTRL, rd);
        `CHK("control readback", 8'h48, rd)
        wr(TEC_OFF_CTRL, 8'h58);
        src.set_level(1'b1);
        src.set_level(1'b0);
        wr(TEC_OFF_CTRL, 8'h48);
        get_cnt(cnt);
        `CHK("falling edge only", 16'h123A, cnt)
    endtask

    task t_overflow;
        set_pre(16'hFFFE);
        wr(TEC_OFF_CTRL, 8'h50);
        set_pre(16'h0010);
        get_cnt(cnt);
        `CHK("preload held while running", 16'hFFFE, cnt)
        src.pulses(2, 3);
        wr(TEC_OFF_CTRL, 8'h40);
        get_cnt(cnt);
        `CHK("overflow reload", 16'h0010, cnt)
        `CHK("irq masked", 1'b0, timer_irq)
        rd8(TEC_OFF_INTERRUPT_CONTROL_REG, rd);
        `CHK("overflow flag", 8'h02, rd)
        wr(TEC_OFF_INTERRUPT_CONTROL_REG, 8'h03);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq enabled", 1'b1, timer_irq)
        wr(TEC_OFF_INTERRUPT_CONTROL_REG, 8'h01);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq cleared", 1'b0, timer_irq)
    endtask

    // Fastest prescale: one tick per 4 clocks, so about 43 clocks give 10 or 11
    task t_timer;
        set_pre(16'h0000);
        wr(TEC_OFF_CTRL, 8'h80);
        wr(TEC_OFF_CTRL, 8'h90);
        repeat (40) @(posedge sys_clk_i);
        wr(TEC_OFF_CTRL, 8'h80);
        get_cnt(cnt);
        `CHK("timer window", 1'b1, (cnt >= 16'h0009 && cnt <= 16'h000D))
        repeat (20) @(posedge sys_clk_i);
        get_cnt(c2);
        `CHK("timer stopped", cnt, c2)
        // Next rate up: one tick per 16 clocks, about 83 clocks give 5 or 6
        set_pre(16'h0000);
        wr(TEC_OFF_CTRL, 8'h81);
        wr(TEC_OFF_CTRL, 8'h91);
        repeat (80) @(posedge sys_clk_i);
        wr(TEC_OFF_CTRL, 8'h81);
        get_cnt(cnt);
        `CHK("prescale select", 1'b1, (cnt >= 16'h0005 && cnt <= 16'h0006))
    endtask

    task t_pulse;
        set_pre(16'h0000);
        src.set_level(1'b1);
        wr(TEC_OFF_CTRL, 8'hC0);
        wr(TEC_OFF_CTRL, 8'hD0);
        src.pulses(1, 40);
        rd8(TEC_OFF_CTRL, rd);
        `CHK("run self cleared", 8'hC0, rd)
        get_cnt(cnt);
        `CHK("pulse window", 1'b1, (cnt >= 16'h0008 && cnt <= 16'h000C))
        src.pulses(1, 20);
        get_cnt(c2);
        `CHK("later pulse ignored", cnt, c2)
    endtask

    // Reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_bytes();
        t_event();
        t_overflow();
        t_timer();
        t_pulse();
        wrap_up();
    end
endmodule
